// ---- rtl/timer16_waveform_mode_decode.sv ----
// mode decoder, compare output actions and control registers of a 16-bit timer
//
// Overview of operation
// - non-PWM: mode 00 disconnects, 01 toggles, 10 clears, 11 sets on match.
// - fast PWM mode 10: clear on match, set at bottom.
// - fast PWM mode 11: set on match, clear at bottom.
// - fast PWM mode 01 toggles channel A only in waveform mode 15.
// - fast PWM modes 10 and 11: match at compare equal top ignored, bottom action still done.
// - dual-slope mode 01 toggles channel A only in waveform modes 9 or 11.
// - dual-slope mode 10: clear on up-count match, set on down-count match.
// - dual-slope mode 11: set on up-count match, clear on down-count match.
// - waveform mode is two low bits of control A, two high of control B.
// - phase correct modes: fixed or register top, update at top, overflow at bottom.
// - mode 0: top 0xffff, immediate update, overflow at max.
// - fast PWM modes: fixed or register top, update at bottom, overflow at top.
// - clear-on-match modes 4 and 12: immediate update, overflow at max.
// - modes 8 and 9: capture or compare A top, update and overflow at bottom.
// - nonzero compare output mode takes the pin if direction is output, except PWM mode 01 where toggle is not allowed.
// - clock select: 0 stops, 1..5 prescaled, 6 and 7 external edges.
// - capture register as top disables the capture input pin.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "timer16_map.svh"

module timer16_waveform_mode_decode
    import timer16_pkg::*;
#(
    parameter logic [7:0] CTRL_A_ADDR = `T1_CTRL_A_OFS,
    parameter logic [7:0] CTRL_B_ADDR = `T1_CTRL_B_OFS,
    parameter int         CHANNELS    = 3
) (
    input  wire logic          clock,
    input  wire logic          rst_b,
    input  wire logic [7:0]    bus_addr,
    input  wire logic [7:0]    bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic      [7:0]    bus_rdata,
    input  wire count_events_t events,
    input  wire logic [2:0]    pin_dir_out,
    output logic               compare_out_a,
    output logic               compare_out_b,
    output logic               compare_out_c,
    output logic      [2:0]    compare_pin_oe_b,
    output mode_decode_t       mode_cfg,
    output logic      [3:0]    waveform_mode,
    output logic      [2:0]    clock_select,
    output logic               counter_stopped,
    output logic               capture_enable,
    output logic               capture_noise_filter,
    output logic               capture_edge_select,
    output logic               overflow_flag,
    output logic               irq
);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [3:0] irq_status_r;
    logic [3:0] irq_status_nxt;
    logic [3:0] irq_enable_r;
    logic [3:0] mode_nxt;
    logic       wr_ctrl_a;
    logic       wr_ctrl_b;
    logic       wr_clear;
    logic       wr_enable;

    assign wr_ctrl_a = bus_wr && (bus_addr == CTRL_A_ADDR);
    assign wr_ctrl_b = bus_wr && (bus_addr == CTRL_B_ADDR);
    assign wr_clear  = bus_wr && (bus_addr == `IRQ_CLEAR_OFS);
    assign wr_enable = bus_wr && (bus_addr == `IRQ_ENABLE_OFS);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_a_r <= `CTRL_A_RST;
            ctrl_b_r <= `CTRL_B_RST;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_r <= bus_wdata;
            end
            // reserved bit is never stored, so it always reads zero
            if (wr_ctrl_b) begin
                ctrl_b_r <= bus_wdata & `CB_WRITE_MASK;
            end
        end
    end

    // two high bits from control B above two low bits from control A
    assign mode_nxt = {ctrl_b_r[`CB_MODE_HI_LSB +: 2], ctrl_a_r[`CA_MODE_LO_LSB +: 2]};

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    mode_decode_t dec;

    // table covers top source, update point and overflow point of every mode
    always_comb begin
        dec = decode_mode(mode_nxt);
    end

    // decoded settings are registered so every output leaves a flip-flop;
    // the datapath therefore sees a control write one cycle after it lands
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_cfg             <= '{TOP_FIXED, `TOP_MAX, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
            waveform_mode        <= 4'h0;
            clock_select         <= 3'h0;
            counter_stopped      <= 1'b1;
            capture_enable       <= 1'b1;
            capture_noise_filter <= 1'b0;
            capture_edge_select  <= 1'b0;
        end else begin
            mode_cfg             <= dec;
            waveform_mode        <= mode_nxt;
            clock_select         <= ctrl_b_r[`CB_CLKSEL_LSB +: 3];
            counter_stopped      <= (ctrl_b_r[`CB_CLKSEL_LSB +: 3] == 3'h0);
            capture_enable       <= (dec.top_src != TOP_CAPTURE);
            capture_noise_filter <= ctrl_b_r[`CB_FILTER_BIT];
            capture_edge_select  <= ctrl_b_r[`CB_EDGE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // compare output actions
    // ----------------------------------------------------------------
    logic [1:0]          com     [CHANNELS];
    logic [CHANNELS-1:0] out_r;
    logic [CHANNELS-1:0] out_nxt;
    logic [CHANNELS-1:0] conn_nxt;
    logic                toggle_a_ok;

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_com
            // channel A sits in the top two bits, then B, then C
            assign com[gi] = ctrl_a_r[`CA_COM_A_LSB - 2*gi +: 2];
        end
    endgenerate

    // toggle mode in PWM only exists for channel A in the OCR-as-top modes
    always_comb begin
        toggle_a_ok = 1'b0;
        unique case (dec.wclass)
            WC_FAST:       toggle_a_ok = (mode_nxt == `MODE_FAST_OCA);
            WC_DUAL_SLOPE: toggle_a_ok = (mode_nxt == `MODE_PFC_OCA) || (mode_nxt == `MODE_PC_OCA);
            default:       toggle_a_ok = 1'b1;
        endcase
    end

    always_comb begin
        out_nxt  = out_r;
        conn_nxt = '0;
        for (int i = 0; i < CHANNELS; i++) begin
            unique case (dec.wclass)
                WC_FAST: begin
                    if (com[i][1]) begin
                        conn_nxt[i] = 1'b1;
                        // bottom first, a real match then overrides it
                        if (events.at_bottom) begin
                            out_nxt[i] = ~com[i][0];
                        end
                        if (events.match[i] && !events.eq_top[i]) begin
                            out_nxt[i] = com[i][0];
                        end
                    end else if (com[i][0] && i == 0 && toggle_a_ok) begin
                        conn_nxt[i] = 1'b1;
                        if (events.match[i]) begin
                            out_nxt[i] = ~out_r[i];
                        end
                    end
                end
                WC_DUAL_SLOPE: begin
                    if (com[i][1]) begin
                        conn_nxt[i] = 1'b1;
                        if (events.match[i]) begin
                            // 10 clears going up, 11 sets going up; reversed going down
                            out_nxt[i] = events.count_up ? com[i][0] : ~com[i][0];
                        end
                    end else if (com[i][0] && i == 0 && toggle_a_ok) begin
                        conn_nxt[i] = 1'b1;
                        if (events.match[i]) begin
                            out_nxt[i] = ~out_r[i];
                        end
                    end
                end
                default: begin
                    conn_nxt[i] = (com[i] != 2'b00);
                    if (events.match[i]) begin
                        unique case (com[i])
                            2'b01:   out_nxt[i] = ~out_r[i];
                            2'b10:   out_nxt[i] = 1'b0;
                            2'b11:   out_nxt[i] = 1'b1;
                            default: out_nxt[i] = out_r[i];
                        endcase
                    end
                end
            endcase
        end
    end

    // output latches keep their value while disconnected, like the pin register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            out_r            <= '0;
            compare_pin_oe_b <= 3'h7;
        end else begin
            out_r            <= out_nxt;
            compare_pin_oe_b <= ~(conn_nxt[2:0] & pin_dir_out);
        end
    end

    assign compare_out_a = out_r[0];
    assign compare_out_b = out_r[1];
    assign compare_out_c = out_r[2];

    // ----------------------------------------------------------------
    // event flags and interrupt
    // ----------------------------------------------------------------
    logic       ovf_event;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;

    always_comb begin
        ovf_event = 1'b0;
        unique case (dec.ovf)
            OVF_AT_TOP:    ovf_event = events.at_top;
            OVF_AT_BOTTOM: ovf_event = events.at_bottom;
            default:       ovf_event = events.at_max;
        endcase
    end

    assign ev_set = {events.match[2:0], ovf_event};
    assign ev_clr = wr_clear ? bus_wdata[3:0] : 4'h0;

    // a set in the same cycle as its clear wins, so no event is lost
    assign irq_status_nxt = (irq_status_r & ~ev_clr) | ev_set;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_status_r <= `IRQ_STATUS_RST;
            irq_enable_r <= `IRQ_ENABLE_RST;
        end else begin
            irq_status_r <= irq_status_nxt;
            if (wr_enable) begin
                irq_enable_r <= bus_wdata[3:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq           <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            irq           <= |(irq_status_nxt & irq_enable_r);
            overflow_flag <= irq_status_nxt[`ST_OVERFLOW_BIT];
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (bus_addr == CTRL_A_ADDR) begin
                bus_rdata <= ctrl_a_r;
            end else if (bus_addr == CTRL_B_ADDR) begin
                bus_rdata <= ctrl_b_r;
            end else if (bus_addr == `IRQ_STATUS_OFS) begin
                bus_rdata <= {4'h0, irq_status_r};
            end else if (bus_addr == `IRQ_ENABLE_OFS) begin
                bus_rdata <= {4'h0, irq_enable_r};
            end else begin
                // clear register is write-only; unmapped addresses read zero
                bus_rdata <= 8'h00;
            end
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule : timer16_waveform_mode_decode

// ---- rtl/timer16_map.svh ----
// register offsets, field positions, reset values and fixed top values of the 16-bit timer mode decoder
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define T1_CTRL_A_OFS      8'h4f
`define T1_CTRL_B_OFS      8'h4e
`define T3_CTRL_A_OFS      8'h8b
`define T3_CTRL_B_OFS      8'h8a
`define IRQ_STATUS_OFS     8'h50
`define IRQ_CLEAR_OFS      8'h51
`define IRQ_ENABLE_OFS     8'h52

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CA_MODE_LO_LSB     0
`define CA_COM_A_LSB       6
`define CB_CLKSEL_LSB      0
`define CB_MODE_HI_LSB     3
`define CB_EDGE_BIT        6
`define CB_FILTER_BIT      7
`define CB_WRITE_MASK      8'hdf
`define ST_OVERFLOW_BIT    0
`define ST_MATCH_LSB       1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_A_RST         8'h00
`define CTRL_B_RST         8'h00
`define IRQ_STATUS_RST     4'h0
`define IRQ_ENABLE_RST     4'h0

// ----------------------------------------------------------------
// fixed top values and special mode numbers
// ----------------------------------------------------------------
`define TOP_8BIT           16'h00ff
`define TOP_9BIT           16'h01ff
`define TOP_10BIT          16'h03ff
`define TOP_MAX            16'hffff
`define MODE_FAST_OCA      4'hf
`define MODE_PFC_OCA       4'h9
`define MODE_PC_OCA        4'hb

`endif

// ---- rtl/timer16_pkg.sv ----
// types and mode decode table of the 16-bit timer mode decoder
`include "timer16_map.svh"

package timer16_pkg;

    typedef enum logic [1:0] {TOP_FIXED, TOP_CAPTURE, TOP_COMPARE_A} top_src_t;
    typedef enum logic [1:0] {UPD_IMMEDIATE, UPD_AT_TOP, UPD_AT_BOTTOM} update_t;
    typedef enum logic [1:0] {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM} ovf_t;
    typedef enum logic [1:0] {WC_NON_PWM, WC_DUAL_SLOPE, WC_FAST} wave_class_t;

    // events from the counter datapath, one-cycle pulses except count_up
    typedef struct packed {
        logic [2:0] match;
        logic [2:0] eq_top;
        logic       at_max;
        logic       at_top;
        logic       at_bottom;
        logic       count_up;
    } count_events_t;

    typedef struct packed {
        top_src_t    top_src;
        logic [15:0] top_fixed;
        update_t     update;
        ovf_t        ovf;
        wave_class_t wclass;
    } mode_decode_t;

    function automatic mode_decode_t decode_mode(input logic [3:0] m);
        mode_decode_t d;
        d = '{TOP_FIXED, `TOP_MAX, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
        unique case (m)
            4'h1:    d = '{TOP_FIXED, `TOP_8BIT, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h2:    d = '{TOP_FIXED, `TOP_9BIT, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h3:    d = '{TOP_FIXED, `TOP_10BIT, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h4:    d = '{TOP_COMPARE_A, `TOP_MAX, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
            4'h5:    d = '{TOP_FIXED, `TOP_8BIT, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'h6:    d = '{TOP_FIXED, `TOP_9BIT, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'h7:    d = '{TOP_FIXED, `TOP_10BIT, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'h8:    d = '{TOP_CAPTURE, `TOP_MAX, UPD_AT_BOTTOM, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h9:    d = '{TOP_COMPARE_A, `TOP_MAX, UPD_AT_BOTTOM, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'ha:    d = '{TOP_CAPTURE, `TOP_MAX, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'hb:    d = '{TOP_COMPARE_A, `TOP_MAX, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'hc:    d = '{TOP_CAPTURE, `TOP_MAX, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
            4'he:    d = '{TOP_CAPTURE, `TOP_MAX, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'hf:    d = '{TOP_COMPARE_A, `TOP_MAX, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            // reserved code 13 falls back to the normal counting mode
            default: d = '{TOP_FIXED, `TOP_MAX, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
        endcase
        return d;
    endfunction : decode_mode

endpackage : timer16_pkg

// ---- tb/port_pin_model.sv ----
// port pin model: pulled-up pins taken over by the compare outputs
`timescale 1ns/10ps
module port_pin_model (
    input  wire logic [2:0] compare_out,
    input  wire logic [2:0] oe_b,
    output logic      [2:0] pin
);
    // a released pin floats to the pull-up level, never the last value
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = oe_b[i] ? 1'b1 : compare_out[i];
        end
    end
endmodule : port_pin_model

// ---- tb/timer16_checker_sva.sv ----
// port assertions of the timer mode decoder
`timescale 1ns/10ps
module timer16_checker_sva
    import timer16_pkg::*;
#(
    parameter logic [7:0] CTRL_A_ADDR = 8'h4f
) (
    input wire logic          clock,
    input wire logic          rst_b,
    input wire logic [7:0]    bus_addr,
    input wire logic [7:0]    bus_wdata,
    input wire logic          bus_wr,
    input wire logic          bus_rd,
    input wire logic [7:0]    bus_rdata,
    input wire count_events_t events,
    input wire logic [2:0]    pin_dir_out,
    input wire logic          compare_out_a,
    input wire logic [2:0]    compare_pin_oe_b,
    input wire mode_decode_t  mode_cfg,
    input wire logic [2:0]    clock_select,
    input wire logic          counter_stopped,
    input wire logic          capture_enable
);
    logic [7:0] ctrl_a_r;
    logic [1:0] wr_d_r;
    logic       quiet;
    // decode lags a write by two edges, so only settled cycles are judged
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_a_r <= 8'h00;
            wr_d_r   <= 2'h0;
        end else begin
            wr_d_r <= {wr_d_r[0], bus_wr};
            if (bus_wr && bus_addr == CTRL_A_ADDR) begin
                ctrl_a_r <= bus_wdata;
            end
        end
    end
    assign quiet = !bus_wr && (wr_d_r == 2'h0);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_read_idle_zero: assert property (!bus_rd |=> bus_rdata == 8'h00) else $error("read data without read");
    a_stop_clock: assert property (counter_stopped == (clock_select == 3'h0)) else $error("stop flag wrong");
    a_capture_off: assert property (capture_enable == (mode_cfg.top_src != TOP_CAPTURE)) else $error("capture");
    a_nonpwm_match: assert property (quiet && mode_cfg.wclass == WC_NON_PWM && events.match[0] && ctrl_a_r[7:6] != 2'h0
        |=> compare_out_a == (ctrl_a_r[7] ? ctrl_a_r[6] : !$past(compare_out_a))) else $error("non-pwm action");
    a_fast_bottom: assert property (quiet && mode_cfg.wclass == WC_FAST && ctrl_a_r[7] && events.at_bottom
        && !events.match[0] |=> compare_out_a == !ctrl_a_r[6]) else $error("bottom action");
    a_fast_top_skip: assert property (quiet && mode_cfg.wclass == WC_FAST && ctrl_a_r[7] && events.match[0]
        && events.eq_top[0] && !events.at_bottom |=> $stable(compare_out_a)) else $error("top match acted");
    a_dual_up: assert property (quiet && mode_cfg.wclass == WC_DUAL_SLOPE && ctrl_a_r[7] && events.match[0]
        && !events.eq_top[0] && events.count_up |=> compare_out_a == ctrl_a_r[6]) else $error("up match");
    a_dual_down: assert property (quiet && mode_cfg.wclass == WC_DUAL_SLOPE && ctrl_a_r[7] && events.match[0]
        && !events.eq_top[0] && !events.count_up |=> compare_out_a == !ctrl_a_r[6]) else $error("down match");
    a_pin_a_off: assert property (quiet && (ctrl_a_r[7:6] == 2'h0 || !pin_dir_out[0])
        |=> compare_pin_oe_b[0]) else $error("pin a driven");
    a_toggle_b_off: assert property (quiet && ctrl_a_r[5:4] == 2'h1 && mode_cfg.wclass != WC_NON_PWM
        |=> compare_pin_oe_b[1]) else $error("pin b driven");
    c_fast: cover property (quiet && mode_cfg.wclass == WC_FAST && events.at_bottom);
    c_dual: cover property (quiet && mode_cfg.wclass == WC_DUAL_SLOPE && events.match[0]);
    c_read: cover property (bus_rd ##1 bus_rdata != 8'h00);
endmodule : timer16_checker_sva

bind timer16_waveform_mode_decode timer16_checker_sva #(.CTRL_A_ADDR(CTRL_A_ADDR)) u_chk (
    .clock(clock), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .events(events), .pin_dir_out(pin_dir_out),
    .compare_out_a(compare_out_a), .compare_pin_oe_b(compare_pin_oe_b), .mode_cfg(mode_cfg),
    .clock_select(clock_select), .counter_stopped(counter_stopped), .capture_enable(capture_enable));

// ---- tb/timer16_waveform_mode_decode_bench.sv ----
// self-checking bench of the timer mode decoder
`timescale 1ns/10ps
`include "timer16_map.svh"
module timer16_waveform_mode_decode_bench
    import timer16_pkg::*;
();
    logic          clock       = 1'b0;
    logic          rst_b       = 1'b0;
    logic [7:0]    bus_addr    = 8'h00;
    logic [7:0]    bus_wdata   = 8'h00;
    logic          bus_wr      = 1'b0;
    logic          bus_rd      = 1'b0;
    count_events_t events      = '0;
    logic [2:0]    pin_dir_out = 3'h7;
    logic [7:0]    bus_rdata;
    logic [2:0]    cout;
    logic [2:0]    oe_b;
    logic [2:0]    pin;
    mode_decode_t  mode_cfg;
    logic [3:0]    wmode;
    logic [2:0]    csel;
    logic          stopped;
    logic          cap_en;
    logic [1:0]    cap_cfg;
    logic          ovf;
    logic          irq;
    int            error_cnt   = 0;
    int            checks_done = 0;

    always #4 clock = ~clock;

    timer16_waveform_mode_decode dut (.clock(clock), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .events(events), .pin_dir_out(pin_dir_out),
        .compare_out_a(cout[0]), .compare_out_b(cout[1]), .compare_out_c(cout[2]), .compare_pin_oe_b(oe_b),
        .mode_cfg(mode_cfg), .waveform_mode(wmode), .clock_select(csel), .counter_stopped(stopped),
        .capture_enable(cap_en), .capture_noise_filter(cap_cfg[1]), .capture_edge_select(cap_cfg[0]),
        .overflow_flag(ovf), .irq(irq));
    port_pin_model pins (.compare_out(cout), .oe_b(oe_b), .pin(pin));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask : rdc
    task automatic cfg(input logic [3:0] m, input logic [7:0] com);
        wr(`T1_CTRL_A_OFS, com | {6'h0, m[1:0]});
        wr(`T1_CTRL_B_OFS, {3'h0, m[3:2], 3'h1});
        repeat (3) @(posedge clock);
    endtask : cfg
    // bit order: match c b a, eq_top c b a, max, top, bottom, count_up
    task automatic ev(input logic [9:0] v);
        @(posedge clock);
        events <= count_events_t'(v);
        @(posedge clock);
        events <= '0;
        #1;
    endtask : ev
    function automatic mode_decode_t exp_mode(input logic [3:0] m);
        logic [15:0] fx;
        fx = (m[1:0] == 2'h1) ? 16'h00ff : (m[1:0] == 2'h2) ? 16'h01ff : 16'h03ff;
        case (m)
            4'h1, 4'h2, 4'h3: return '{TOP_FIXED, fx, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h4:             return '{TOP_COMPARE_A, 16'hffff, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
            4'h5, 4'h6, 4'h7: return '{TOP_FIXED, fx, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'h8:             return '{TOP_CAPTURE, 16'hffff, UPD_AT_BOTTOM, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'h9:             return '{TOP_COMPARE_A, 16'hffff, UPD_AT_BOTTOM, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'ha:             return '{TOP_CAPTURE, 16'hffff, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'hb:             return '{TOP_COMPARE_A, 16'hffff, UPD_AT_TOP, OVF_AT_BOTTOM, WC_DUAL_SLOPE};
            4'hc:             return '{TOP_CAPTURE, 16'hffff, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
            4'he:             return '{TOP_CAPTURE, 16'hffff, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            4'hf:             return '{TOP_COMPARE_A, 16'hffff, UPD_AT_BOTTOM, OVF_AT_TOP, WC_FAST};
            default:          return '{TOP_FIXED, 16'hffff, UPD_IMMEDIATE, OVF_AT_MAX, WC_NON_PWM};
        endcase
    endfunction : exp_mode

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_modes();
        chk({oe_b, stopped, cap_en, irq, ovf}, 7'h7c);
        rdc(8'h00, 8'h00);
        for (int m = 0; m < 16; m++) begin
            wr(`T1_CTRL_A_OFS, {6'h0, m[1:0]});
            wr(`T1_CTRL_B_OFS, {3'h0, m[3:2], m[2:0]});
            repeat (3) @(posedge clock);
            chk({wmode, stopped, csel}, {m[3:0], m[2:0] == 3'h0, m[2:0]});
            chk(mode_cfg, exp_mode(m[3:0]));
            chk(cap_en, !(m inside {8, 10, 12, 14}));
        end
        wr(`T1_CTRL_B_OFS, 8'hff);
        rdc(`T1_CTRL_B_OFS, 8'hdf);
        chk(cap_cfg, 2'h3);
        $display("test modes done");
    endtask : t_modes
    task automatic t_nonpwm();
        cfg(4'h0, 8'h40);
        ev(10'h080);
        chk({cout[0], oe_b[0], pin[0]}, 3'h5);
        ev(10'h080);
        chk(cout[0], 1'b0);
        cfg(4'h0, 8'hc0);
        ev(10'h080);
        chk(cout[0], 1'b1);
        cfg(4'h0, 8'h80);
        ev(10'h080);
        chk(pin[0], 1'b0);
        @(posedge clock);
        pin_dir_out <= 3'h6;
        repeat (3) @(posedge clock);
        chk({oe_b[0], pin[0]}, 2'h3);
        pin_dir_out <= 3'h7;
        $display("test non-pwm done");
    endtask : t_nonpwm
    task automatic t_fast();
        cfg(4'h5, 8'h80);
        ev(10'h002);
        chk(cout[0], 1'b1);
        ev(10'h080);
        chk(cout[0], 1'b0);
        ev(10'h002);
        ev(10'h090);
        chk(cout[0], 1'b1);
        cfg(4'h5, 8'hc0);
        ev(10'h002);
        chk(cout[0], 1'b0);
        ev(10'h090);
        chk(cout[0], 1'b0);
        ev(10'h080);
        chk(cout[0], 1'b1);
        $display("test fast done");
    endtask : t_fast
    task automatic t_toggle();
        logic [3:0] ml[8] = '{4'h5, 4'he, 4'hf, 4'h9, 4'hb, 4'ha, 4'h1, 4'h4};
        logic       on;
        logic [2:0] was;
        foreach (ml[i]) begin
            cfg(ml[i], 8'h54);
            on = (ml[i] == 4'hf) || (ml[i] == 4'h9) || (ml[i] == 4'hb) || (ml[i] == 4'h4);
            chk(oe_b, (ml[i] == 4'h4) ? 3'h0 : {2'h3, !on});
            was = cout;
            ev(10'h380);
            chk(cout, was ^ {{2{ml[i] == 4'h4}}, on});
        end
        $display("test toggle done");
    endtask : t_toggle
    task automatic t_dual();
        cfg(4'h1, 8'h80);
        ev(10'h081);
        chk(cout[0], 1'b0);
        ev(10'h080);
        chk(cout[0], 1'b1);
        cfg(4'h1, 8'hc0);
        ev(10'h080);
        chk(cout[0], 1'b0);
        ev(10'h081);
        chk(cout[0], 1'b1);
        $display("test dual done");
    endtask : t_dual
    task automatic t_irq();
        cfg(4'h5, 8'h00);
        wr(`IRQ_CLEAR_OFS, 8'h0f);
        ev(10'h008);
        chk(ovf, 1'b0);
        ev(10'h004);
        chk({ovf, irq}, 2'h2);
        wr(`IRQ_ENABLE_OFS, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk(irq, 1'b1);
        ev(10'h100);
        rdc(`IRQ_STATUS_OFS, 8'h05);
        wr(`IRQ_CLEAR_OFS, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk({ovf, irq}, 2'h0);
        rdc(`IRQ_CLEAR_OFS, 8'h00);
        $display("test interrupt done");
    endtask : t_irq
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        t_modes();
        t_nonpwm();
        t_fast();
        t_toggle();
        t_dual();
        t_irq();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end
endmodule : timer16_waveform_mode_decode_bench
